//--- design/charge_start_consts.svh
`ifndef CHARGE_START_CONSTS_SVH
`define CHARGE_START_CONSTS_SVH

// ==========================================================
// Clock and timebase
// ==========================================================
`define MCLK_PERIOD_NS 25
`define TICK_TIME_MS 125
`define TICK_CYCLES ((`TICK_TIME_MS * 1000000) / `MCLK_PERIOD_NS)

// ==========================================================
// Times in milliseconds and their tick counts
// ==========================================================
`define BLINK_ON_MS 125
`define BLINK_OFF_MS 1375
`define POWERUP_MS 1500
`define BLINK_ON_TICKS (`BLINK_ON_MS / `TICK_TIME_MS)
`define BLINK_PERIOD_TICKS ((`BLINK_ON_MS + `BLINK_OFF_MS) / `TICK_TIME_MS)
`define POWERUP_TICKS (`POWERUP_MS / `TICK_TIME_MS)
`define HOLDOFF_STEP_TICKS 8'h28

// ==========================================================
// Analog levels as converter codes
// ==========================================================
`define CODE_W 10
`define ADC_FULL_SCALE 1024
`define END_DISCHARGE_CODE ((`ADC_FULL_SCALE * 2) / 10)
`define LOW_TEMP_FAULT_CODE ((`ADC_FULL_SCALE * 4) / 10)
`define HIGH_TEMP_DIVISOR 8

// ==========================================================
// Three-level select input encoding
// ==========================================================
`define LEVEL_LOW 2'h0
`define LEVEL_HIGH 2'h1
`define LEVEL_FLOAT 2'h2

// ==========================================================
// Register offsets, fields and reset values
// ==========================================================
`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define IRQ_STATUS_OFFSET 8'h08
`define IRQ_CLEAR_OFFSET 8'h0c
`define IRQ_ENABLE_OFFSET 8'h10
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 32'h00000001
`define IRQ_ENABLE_RESET 3'h0
`define IRQ_START_BIT 0
`define IRQ_END_BIT 1
`define IRQ_PENDING_BIT 2
`define IRQ_W 3

`endif

//--- design/charge_start_pkg.sv
package charge_start_pkg;

    // APB request group from the bus master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // Charger sequencing states
    typedef enum logic [1:0] {
        ST_POWERUP = 2'b00,
        ST_WAIT = 2'b01,
        ST_FAST = 2'b10
    } charge_state_e;

    // Events that feed the sticky status bits
    typedef struct packed {
        logic pending_entered;
        logic fast_ended;
        logic fast_started;
    } charge_events_s;

endpackage

//--- design/fast_charge_start_control.sv
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "charge_start_consts.svh"

// How it works
// - Bad voltage or temperature holds charge pending
// - Pending blinks LED 0.125 s on, 1.375 s off
// - Start needs cell above end-discharge level
// - Low fault 0.4 supply; high fault derived
// - Start uses high fault; running uses cutoff
// - Start on insertion, power-up or command
// - LED steadily lit during fast charge
// - Hold-off disables voltage terminations, select-chosen
// - Insertion is falling crossing of max limit
// - Wait 1.5 s after power, sample commands
// - Equal commands at power-up start immediately
// - Different commands wait for valid edge
// - Command edge polarity follows discharge command
// - Cell above max limit ends charging
module fast_charge_start_control #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input charge_start_pkg::apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic charge_command_in,
    input wire logic discharge_command_in,
    input wire logic [1:0] hold_off_select_a,
    input wire logic [1:0] hold_off_select_b,
    input wire logic [`CODE_W-1:0] cell_voltage_sense,
    input wire logic [`CODE_W-1:0] max_cell_limit,
    input wire logic [`CODE_W-1:0] thermistor_sense,
    input wire logic [`CODE_W-1:0] temp_cutoff_level,
    output logic charge_status_led,
    output logic fast_charge_active,
    output logic charge_pending,
    output logic voltage_term_enable
);
    import charge_start_pkg::*;

    localparam logic [`CODE_W-1:0] END_DISCHARGE_LEVEL = `CODE_W'(`END_DISCHARGE_CODE);
    localparam logic [`CODE_W-1:0] LOW_TEMP_FAULT_LEVEL = `CODE_W'(`LOW_TEMP_FAULT_CODE);
    localparam logic [22:0] TICK_LAST = 23'(TICK_CYCLES - 1);
    localparam logic [3:0] BLINK_ON = 4'(`BLINK_ON_TICKS);
    localparam logic [3:0] BLINK_LAST = 4'(`BLINK_PERIOD_TICKS - 1);
    localparam logic [3:0] POWERUP_LAST = 4'(`POWERUP_TICKS - 1);

    // Three-level select to a position 0..2
    function automatic logic [7:0] level_index(input logic [1:0] sel);
        return (sel == `LEVEL_HIGH) ? 8'h01 : (sel == `LEVEL_FLOAT) ? 8'h02 : 8'h00;
    endfunction

    // ==========================================================
    // Synchronised command pins
    // ==========================================================
    logic [1:0] cmd_level, cmd_rise, cmd_fall;

    sync_edge #(.W(2)) cmd_sync (
        .mclk(mclk),
        .rstn(rstn),
        .async_in({discharge_command_in, charge_command_in}),
        .level(cmd_level),
        .rise(cmd_rise),
        .fall(cmd_fall)
    );

    // ==========================================================
    // Comparator results, registered once
    // ==========================================================
    logic cell_above_max, cell_above_max_prev, cell_above_edv, temp_start_ok, temp_run_ok;
    logic next_cell_above_max, next_cell_above_edv, next_temp_start_ok, next_temp_run_ok;
    logic [`CODE_W-1:0] high_temp_fault_level;

    // Hot reads low; a cutoff above the cold fault collapses the window
    always_comb
    begin
        high_temp_fault_level = (temp_cutoff_level >= LOW_TEMP_FAULT_LEVEL) ? temp_cutoff_level
            : temp_cutoff_level + `CODE_W'((LOW_TEMP_FAULT_LEVEL - temp_cutoff_level) / `HIGH_TEMP_DIVISOR);
        next_cell_above_max = cell_voltage_sense > max_cell_limit;
        next_cell_above_edv = cell_voltage_sense > END_DISCHARGE_LEVEL;
        next_temp_start_ok = (thermistor_sense < LOW_TEMP_FAULT_LEVEL)
            && (thermistor_sense > high_temp_fault_level);
        next_temp_run_ok = (thermistor_sense < LOW_TEMP_FAULT_LEVEL)
            && (thermistor_sense >= temp_cutoff_level);
    end

    // Comparator result registers
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cell_above_max <= 1'b0;
            cell_above_max_prev <= 1'b0;
            cell_above_edv <= 1'b0;
            temp_start_ok <= 1'b0;
            temp_run_ok <= 1'b0;
        end
        else
        begin
            cell_above_max <= next_cell_above_max;
            cell_above_max_prev <= cell_above_max;
            cell_above_edv <= next_cell_above_edv;
            temp_start_ok <= next_temp_start_ok;
            temp_run_ok <= next_temp_run_ok;
        end
    end

    // ==========================================================
    // Free-running timebase
    // ==========================================================
    logic [22:0] tick_cnt, next_tick_cnt;
    logic tick;

    always_comb
    begin
        tick = tick_cnt == TICK_LAST;
        next_tick_cnt = tick ? 23'h000000 : tick_cnt + 23'h000001;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            tick_cnt <= 23'h000000;
        else
            tick_cnt <= next_tick_cnt;
    end

    // ==========================================================
    // Start sequencing
    // ==========================================================
    charge_state_e state, next_state;
    logic [3:0] powerup_cnt, next_powerup_cnt;
    logic [3:0] blink_cnt, next_blink_cnt;
    // Nine bits: the longest select choice is 360 ticks
    logic [8:0] holdoff_cnt, next_holdoff_cnt, holdoff_ticks;
    logic start_req, next_start_req;
    logic next_led, next_pending, next_active, next_term_en;
    logic window_ok, cmd_edge_ok, insertion, charger_enable;
    charge_events_s events;

    always_comb
    begin
        window_ok = cell_above_edv && !cell_above_max && temp_start_ok;
        // edge polarity set by discharge command
        cmd_edge_ok = (!cmd_level[1] && cmd_rise[0]) || (cmd_level[1] && cmd_fall[0]);
        insertion = cell_above_max_prev && !cell_above_max;
        holdoff_ticks = 9'((16'(level_index(hold_off_select_a)) * 16'h0003
            + 16'(level_index(hold_off_select_b)) + 16'h0001) * 16'(`HOLDOFF_STEP_TICKS));
        next_state = state;
        next_powerup_cnt = powerup_cnt;
        next_blink_cnt = blink_cnt;
        next_holdoff_cnt = holdoff_cnt;
        next_start_req = start_req;
        events = '0;
        unique case (state)
            ST_POWERUP:
            begin
                // hold reset for 1.5 s, then sample
                if (tick)
                begin
                    next_powerup_cnt = powerup_cnt + 4'h1;
                    if (powerup_cnt == POWERUP_LAST)
                    begin
                        next_state = ST_WAIT;
                        // unequal commands wait for an edge
                        next_start_req = cmd_level[0] == cmd_level[1];
                    end
                end
            end
            ST_WAIT:
            begin
                if (insertion || cmd_edge_ok)
                    next_start_req = 1'b1;
                if (start_req && window_ok && charger_enable)
                begin
                    next_state = ST_FAST;
                    next_start_req = 1'b0;
                    next_holdoff_cnt = holdoff_ticks;
                    events.fast_started = 1'b1;
                end
                // Blink phase restarts while the window is fine
                if (window_ok)
                    next_blink_cnt = 4'h0;
                else if (tick)
                    next_blink_cnt = (blink_cnt == BLINK_LAST) ? 4'h0 : blink_cnt + 4'h1;
            end
            ST_FAST:
            begin
                if (tick && holdoff_cnt != 9'h000)
                    next_holdoff_cnt = holdoff_cnt - 9'h001;
                // max limit ends charging after hold-off
                if (!temp_run_ok || !charger_enable || (voltage_term_enable && cell_above_max))
                begin
                    next_state = ST_WAIT;
                    next_blink_cnt = 4'h0;
                    events.fast_ended = 1'b1;
                end
            end
            default:
            begin
                next_state = ST_POWERUP;
            end
        endcase
        // short low, long high while pending
        next_pending = (next_state == ST_WAIT) && !window_ok;
        next_active = next_state == ST_FAST;
        events.pending_entered = next_pending && !charge_pending;
        if (next_active)
            next_led = 1'b0;
        else if (next_pending)
            next_led = next_blink_cnt >= BLINK_ON;
        else
            next_led = 1'b1;
        next_term_en = next_active && (next_holdoff_cnt == 9'h000);
    end

    // Sequencer registers; LED dark until the window is known
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_POWERUP;
            powerup_cnt <= 4'h0;
            blink_cnt <= 4'h0;
            holdoff_cnt <= 9'h000;
            start_req <= 1'b0;
            charge_status_led <= 1'b1;
            charge_pending <= 1'b0;
            fast_charge_active <= 1'b0;
            voltage_term_enable <= 1'b0;
        end
        else
        begin
            state <= next_state;
            powerup_cnt <= next_powerup_cnt;
            blink_cnt <= next_blink_cnt;
            holdoff_cnt <= next_holdoff_cnt;
            start_req <= next_start_req;
            charge_status_led <= next_led;
            charge_pending <= next_pending;
            fast_charge_active <= next_active;
            voltage_term_enable <= next_term_en;
        end
    end

    // ==========================================================
    // APB slave and interrupt registers
    // ==========================================================
    logic [31:0] ctrl, next_ctrl;
    logic [`IRQ_W-1:0] irq_status, next_irq_status;
    logic [`IRQ_W-1:0] irq_enable, next_irq_enable;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq;
    logic access, commit, mapped;
    logic [`IRQ_W-1:0] clear_bits;

    assign charger_enable = ctrl[`CTRL_ENABLE_BIT];

    // One wait state: pready is registered, writes land on its edge
    always_comb
    begin
        access = apb_req.psel && apb_req.penable;
        commit = access && pready;
        mapped = (apb_req.paddr[31:8] == 24'h000000) && (apb_req.paddr[1:0] == 2'h0)
            && (apb_req.paddr[7:0] <= `IRQ_ENABLE_OFFSET);
        next_pready = access && !pready;
        next_pslverr = access && !pready && !mapped;
        next_prdata = 32'h00000000;
        next_ctrl = ctrl;
        next_irq_enable = irq_enable;
        clear_bits = '0;
        if (access && !pready && !apb_req.pwrite)
        begin
            unique case (apb_req.paddr[7:0])
                `CTRL_OFFSET: next_prdata = ctrl;
                `STATUS_OFFSET: next_prdata = {24'h000000, window_ok, start_req,
                    voltage_term_enable, charge_pending, fast_charge_active,
                    charge_status_led, state};
                `IRQ_STATUS_OFFSET: next_prdata = {29'h00000000, irq_status};
                `IRQ_ENABLE_OFFSET: next_prdata = {29'h00000000, irq_enable};
                default: next_prdata = 32'h00000000;
            endcase
        end
        if (commit && apb_req.pwrite && mapped)
        begin
            if (apb_req.paddr[7:0] == `CTRL_OFFSET)
                next_ctrl = {31'h00000000, apb_req.pwdata[`CTRL_ENABLE_BIT]};
            if (apb_req.paddr[7:0] == `IRQ_CLEAR_OFFSET)
                clear_bits = apb_req.pwdata[`IRQ_W-1:0];
            if (apb_req.paddr[7:0] == `IRQ_ENABLE_OFFSET)
                next_irq_enable = apb_req.pwdata[`IRQ_W-1:0];
        end
        // A new event beats a clear in the same cycle
        next_irq_status = (irq_status & ~clear_bits) | events;
        next_irq = |(next_irq_status & next_irq_enable);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl <= `CTRL_RESET;
            irq_status <= '0;
            irq_enable <= `IRQ_ENABLE_RESET;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end

endmodule

//--- design/sync_edge.sv
`timescale 1ns/1ps

module sync_edge #(
    parameter int W = 2
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    // ==========================================================
    // Two-flop synchroniser plus one history stage
    // ==========================================================
    // Edges from stable samples only
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end
        else
        begin
            meta <= async_in;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level = stable;
    assign rise = stable & ~prev;
    assign fall = ~stable & prev;

endmodule

//--- verif/fast_charge_start_control_test.sv
`timescale 1ns/1ps
`include "charge_start_consts.svh"
// Compare, count and report at once
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module fast_charge_start_control_test;
    import charge_start_pkg::*;
    localparam int unsigned TICK = 8;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    apb_req_s apb_req = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, err, charge_command_in, discharge_command_in;
    logic [1:0] hold_off_select_a, hold_off_select_b;
    logic [`CODE_W-1:0] cell_voltage_sense, max_cell_limit, thermistor_sense, temp_cutoff_level;
    logic charge_status_led, fast_charge_active, charge_pending, voltage_term_enable;
    int fails = 0;
    int comparisons = 0;
    int n;
    // ==========================================
    // Clock, design and far side
    // ==========================================
    always #12.5 mclk = ~mclk;
    fast_charge_start_control #(.TICK_CYCLES(TICK)) fast_charge_start_control_i (
        .mclk(mclk), .rstn(rstn), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .charge_command_in(charge_command_in), .discharge_command_in(discharge_command_in),
        .hold_off_select_a(hold_off_select_a), .hold_off_select_b(hold_off_select_b),
        .cell_voltage_sense(cell_voltage_sense), .max_cell_limit(max_cell_limit),
        .thermistor_sense(thermistor_sense), .temp_cutoff_level(temp_cutoff_level),
        .charge_status_led(charge_status_led), .fast_charge_active(fast_charge_active),
        .charge_pending(charge_pending), .voltage_term_enable(voltage_term_enable));
    pack_model pack_model_i (
        .mclk(mclk), .charge_command_in(charge_command_in), .discharge_command_in(discharge_command_in),
        .hold_off_select_a(hold_off_select_a), .hold_off_select_b(hold_off_select_b),
        .cell_voltage_sense(cell_voltage_sense), .max_cell_limit(max_cell_limit),
        .thermistor_sense(thermistor_sense), .temp_cutoff_level(temp_cutoff_level));
    // ==========================================
    // Bus and wait helpers
    // ==========================================
    // One transfer, held until pready
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        do
            @(posedge mclk);
        while (!pready);
        rd = prdata;
        err = pslverr;
        apb_req <= '0;
    endtask
    // Cycles until an output level
    task automatic wait_on(input int s, input logic v, input int lim);
        n = 0;
        while ((s == 0 ? fast_charge_active : s == 1 ? charge_pending : s == 2 ? charge_status_led
                : voltage_term_enable) !== v && n < lim)
        begin
            @(posedge mclk);
            n++;
        end
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_regs();
        apb(1'b0, `CTRL_OFFSET, 0);
        `CHECK(rd, `CTRL_RESET) // Enable set after reset
        apb(1'b0, `IRQ_ENABLE_OFFSET, 0);
        `CHECK(rd, 32'h0) // Interrupts masked after reset
        apb(1'b0, 32'h14, 0);
        `CHECK({err, rd}, {1'b1, 32'h0}) // Unmapped place refused
        $display("Registers done");
    endtask
    task automatic t_pending();
        wait_on(1, 1'b1, 300);
        `CHECK(fast_charge_active, 1'b0)
        wait_on(2, 1'b0, 200);
        wait_on(2, 1'b1, 50);
        `CHECK(n, TICK)
        wait_on(2, 1'b0, 200);
        `CHECK(n, 11 * TICK)
        apb(1'b0, `IRQ_STATUS_OFFSET, 0);
        `CHECK({rd[`IRQ_PENDING_BIT], irq}, 2'b10)
        apb(1'b1, `IRQ_ENABLE_OFFSET, 32'h4);
        apb(1'b0, `IRQ_ENABLE_OFFSET, 0);
        `CHECK({rd, irq}, {32'h4, 1'b1})
        apb(1'b1, `IRQ_CLEAR_OFFSET, 32'h4);
        apb(1'b1, `IRQ_ENABLE_OFFSET, 32'h0);
        `CHECK(irq, 1'b0) // Cleared event drops the line
        pack_model_i.set_cell(10'd204);
        repeat (20) @(posedge mclk);
        `CHECK(charge_pending, 1'b1)
        pack_model_i.set_cell(10'd205);
        repeat (30) @(posedge mclk);
        `CHECK({charge_pending, fast_charge_active}, 2'b00)
        $display("Pending done");
    endtask
    // Wrong then right edge, hold-off, end
    task automatic t_command(input logic d, input logic [1:0] a, input logic [1:0] b, input int ticks);
        pack_model_i.set_sel(a, b);
        pack_model_i.set_cmd(~d, ~d);
        pack_model_i.set_cmd(~d, d);
        pack_model_i.set_cmd(d, d);
        repeat (20) @(posedge mclk);
        `CHECK(fast_charge_active, 1'b0)
        pack_model_i.set_cmd(~d, d);
        wait_on(0, 1'b1, 20);
        `CHECK({fast_charge_active, charge_status_led, voltage_term_enable}, 3'b100)
        wait_on(3, 1'b1, ticks * TICK + 50);
        `CHECK(n >= (ticks - 1) * TICK && n <= ticks * TICK + 4, 1'b1)
        if (d)
            apb(1'b1, `CTRL_OFFSET, 32'h0);
        else
            pack_model_i.set_cell(10'd900);
        wait_on(0, 1'b0, 10);
        `CHECK(fast_charge_active, 1'b0)
        apb(1'b1, `CTRL_OFFSET, 32'h1);
        $display("Command done");
    endtask
    task automatic t_insert();
        logic [`CODE_W-1:0] lvl [6] = '{10'd226, 10'd227, 10'd409, 10'd408, 10'd401, 10'd402};
        pack_model_i.set_temp(10'd240);
        pack_model_i.set_cell(10'd500);
        wait_on(0, 1'b1, 10);
        `CHECK(fast_charge_active, 1'b1)
        pack_model_i.set_temp(10'd215);
        repeat (20) @(posedge mclk);
        `CHECK(fast_charge_active, 1'b1)
        pack_model_i.set_temp(10'd190);
        repeat (10) @(posedge mclk);
        `CHECK({fast_charge_active, charge_pending}, 2'b01)
        for (int i = 0; i < 6; i++)
        begin
            if (i == 4)
                pack_model_i.set_limits(10'd600, 10'd400);
            pack_model_i.set_temp(lvl[i]);
            repeat (10) @(posedge mclk);
            `CHECK(charge_pending, (i % 2 == 0))
        end
        $display("Insertion done");
    endtask
    task automatic t_powerup();
        pack_model_i.set_cmd(1'b0, 1'b0);
        rstn <= 1'b0;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        wait_on(0, 1'b1, 200);
        `CHECK(n >= 12 * TICK - 4 && n <= 12 * TICK + 8, 1'b1)
        $display("Power-up done");
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_pending();
        t_command(1'b1, `LEVEL_LOW, `LEVEL_LOW, 40);
        t_command(1'b0, `LEVEL_FLOAT, `LEVEL_FLOAT, 360);
        t_insert();
        t_powerup();
        finish_test();
    end
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        finish_test();
    end
endmodule

//--- verif/fast_charge_start_properties.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the start controller
// ==========================================
module fast_charge_start_checks #(
    parameter int unsigned TICK_CYCLES = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input charge_start_pkg::apb_req_s apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic charge_status_led,
    input wire logic fast_charge_active,
    input wire logic charge_pending,
    input wire logic voltage_term_enable
);
    import charge_start_pkg::*;
    int unsigned since_rst, since_fast, low_run;
    int unsigned next_since_rst, next_since_fast, next_low_run;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // Cycles since reset, since start, of lit blink
    always_comb
    begin
        next_since_rst = since_rst + 1;
        next_since_fast = fast_charge_active ? since_fast + 1 : 0;
        next_low_run = (charge_pending && !charge_status_led) ? low_run + 1 : 0;
    end
    // Cleared by reset so a second reset restarts delays
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            since_rst <= 0;
            since_fast <= 0;
            low_run <= 0;
        end
        else
        begin
            since_rst <= next_since_rst;
            since_fast <= next_since_fast;
            low_run <= next_low_run;
        end
    end
    chk_fast_led_lit: assert property (fast_charge_active |-> !charge_status_led)
        else $error("LED not lit during fast charge");
    chk_pending_no_fast: assert property (charge_pending |-> !fast_charge_active)
        else $error("Fast charge while pending");
    chk_term_in_fast: assert property (voltage_term_enable |-> fast_charge_active)
        else $error("Voltage termination outside fast charge");
    chk_holdoff_length: assert property (voltage_term_enable |-> since_fast >= 39 * TICK_CYCLES)
        else $error("Hold-off ended early");
    chk_powerup_delay: assert property (fast_charge_active |-> since_rst >= 11 * TICK_CYCLES)
        else $error("Fast charge before power-up delay");
    chk_blink_on_len: assert property (low_run <= TICK_CYCLES)
        else $error("Pending LED lit too long");
    chk_pready_answer: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
        else $error("Missing bus answer");
    chk_pready_single: assert property (pready |=> !pready)
        else $error("Bus answer held too long");
    chk_error_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("Error response carries data");
    cover property ($rose(fast_charge_active));
    cover property ($rose(voltage_term_enable));
    cover property (pslverr);
endmodule

bind fast_charge_start_control fast_charge_start_checks #(.TICK_CYCLES(TICK_CYCLES)) fast_charge_start_checks_i (
    .mclk(mclk), .rstn(rstn), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .charge_status_led(charge_status_led), .fast_charge_active(fast_charge_active),
    .charge_pending(charge_pending), .voltage_term_enable(voltage_term_enable));

//--- verif/pack_model.sv
`timescale 1ns/1ps
`include "charge_start_consts.svh"
// ==========================================
// Command source, battery pack and thermistor
// ==========================================
module pack_model (
    input wire logic mclk,
    output logic charge_command_in,
    output logic discharge_command_in,
    output logic [1:0] hold_off_select_a,
    output logic [1:0] hold_off_select_b,
    output logic [`CODE_W-1:0] cell_voltage_sense,
    output logic [`CODE_W-1:0] max_cell_limit,
    output logic [`CODE_W-1:0] thermistor_sense,
    output logic [`CODE_W-1:0] temp_cutoff_level
);
    // Flat cell, differing commands
    initial
    begin
        charge_command_in = 1'b0;
        discharge_command_in = 1'b1;
        cell_voltage_sense = 10'd100;
        max_cell_limit = 10'd800;
        thermistor_sense = 10'd300;
        temp_cutoff_level = 10'd200;
        hold_off_select_a = `LEVEL_LOW;
        hold_off_select_b = `LEVEL_LOW;
    end
    // commands change one edge at a time
    task automatic set_cmd(input logic c, input logic d);
        @(posedge mclk);
        charge_command_in <= c;
        discharge_command_in <= d;
    endtask
    task automatic set_cell(input logic [`CODE_W-1:0] v);
        @(posedge mclk);
        cell_voltage_sense <= v;
    endtask
    // Thermistor falls as pack heats
    task automatic set_temp(input logic [`CODE_W-1:0] v);
        @(posedge mclk);
        thermistor_sense <= v;
    endtask
    task automatic set_sel(input logic [1:0] a, input logic [1:0] b);
        @(posedge mclk);
        hold_off_select_a <= a;
        hold_off_select_b <= b;
    endtask
    // Max cell and cutoff limits
    task automatic set_limits(input logic [`CODE_W-1:0] m, input logic [`CODE_W-1:0] t);
        @(posedge mclk);
        max_cell_limit <= m;
        temp_cutoff_level <= t;
    endtask
endmodule
